// ### src/channel_clock_dividers.sv
/*
  four channel clock dividers with an APB register slave.
  assumes clk is the routed divider input clock and that software keeps the programming rules.
*/
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "clk_div_regs.svh"

module channel_clock_dividers
  import clk_div_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [3:0]  chan_clk_out
);

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  cfg_byte_t        cfg_q [`NUM_CFG];
  logic [3:0]       slot;
  logic             slot_hit;
  logic [9:0]       idx;
  logic             wr_en;
  logic             rd_en;
  logic             sync_q;
  logic [31:0]      prdata_q;
  logic             pslverr_q;
  logic [`NUM_STAGES-1:0] hi_q;
  logic [`NUM_STAGES-1:0] dly_busy;
  logic             reg_hit;
  logic [31:0]      status_word;

  assign idx   = paddr[11:2];
  assign wr_en = psel & penable & pwrite;
  // read data loads at setup and stands with pready
  assign rd_en = psel & ~penable & ~pwrite;
  assign reg_hit     = slot_hit | (idx == `IDX_STATUS) | (idx == `IDX_SYNC_CTRL);
  assign status_word = {20'h0_0000, dly_busy, hi_q};

  always_comb
  begin
    slot     = 4'h0;
    slot_hit = 1'b1;
    case (idx)
      `IDX_CH0_COUNTS: slot = 4'h0;
      `IDX_CH0_PHASE:  slot = 4'h1;
      `IDX_CH1_COUNTS: slot = 4'h2;
      `IDX_CH1_PHASE:  slot = 4'h3;
      `IDX_CH2_S1:     slot = 4'h4;
      `IDX_CH2_S2:     slot = 4'h5;
      `IDX_CH2_BYPASS: slot = 4'h6;
      `IDX_CH2_DUTY:   slot = 4'h7;
      `IDX_CH3_S1:     slot = 4'h8;
      `IDX_CH3_S2:     slot = 4'h9;
      `IDX_CH3_BYPASS: slot = 4'hA;
      `IDX_CH3_DUTY:   slot = 4'hB;
      default:         slot_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < `NUM_CFG; i++)
        cfg_q[i] <= `CFG_RESET;
    end
    else if (wr_en && slot_hit)
    begin
      cfg_q[slot] <= pwdata[7:0];
    end
  end

  // sync request, write one to pulse
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sync_q <= 1'b0;
    else
      sync_q <= wr_en && idx == `IDX_SYNC_CTRL && pwdata[`SYNC_BIT];
  end

  // ---------------------------------------------------------------
  // apb read path
  // ---------------------------------------------------------------
  // read data and error decided in the setup cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pslverr_q <= 1'b0;
      if (rd_en)
      begin
        if (slot_hit)
          prdata_q <= {24'h00_0000, cfg_q[slot]};
        else if (idx == `IDX_STATUS)
          prdata_q <= status_word;
        else if (idx == `IDX_SYNC_CTRL)
          prdata_q <= 32'h0000_0000;
        else
          prdata_q <= 32'h0000_0000;
      end
      if (psel && !penable)
        pslverr_q <= ~reg_hit;
    end
  end

  // ---------------------------------------------------------------
  // apb handshake
  // ---------------------------------------------------------------
  // no wait state: setup decodes, first access cycle answers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pready <= 1'b0;
    else
      pready <= psel & ~penable;
  end

  assign prdata  = prdata_q;
  assign pslverr = pslverr_q & pready;

  // ---------------------------------------------------------------
  // stage setup
  // ---------------------------------------------------------------
  // stage order: ch0, ch1, ch2.1, ch2.2, ch3.1, ch3.2
  cnt_field_t       st_low  [`NUM_STAGES];
  cnt_field_t       st_high [`NUM_STAGES];
  logic [4:0]       st_dly  [`NUM_STAGES];
  logic [`NUM_STAGES-1:0] st_adv;
  logic [`NUM_STAGES-1:0] st_rise;
  logic [`NUM_STAGES-1:0] st_fall;
  logic [`NUM_STAGES-1:0] st_odd;
  logic [4:0]       phase0;
  logic [4:0]       phase1;

  // low/high fields, cycles minus one
  assign st_low[0]  = cfg_q[0][`LOW_MSB:`LOW_LSB];
  assign st_high[0] = cfg_q[0][`HIGH_MSB:`HIGH_LSB];
  assign st_low[1]  = cfg_q[2][`LOW_MSB:`LOW_LSB];
  assign st_high[1] = cfg_q[2][`HIGH_MSB:`HIGH_LSB];
  assign st_low[2]  = cfg_q[4][`LOW_MSB:`LOW_LSB];
  assign st_high[2] = cfg_q[4][`HIGH_MSB:`HIGH_LSB];
  assign st_low[3]  = cfg_q[5][`LOW_MSB:`LOW_LSB];
  assign st_high[3] = cfg_q[5][`HIGH_MSB:`HIGH_LSB];
  assign st_low[4]  = cfg_q[8][`LOW_MSB:`LOW_LSB];
  assign st_high[4] = cfg_q[8][`HIGH_MSB:`HIGH_LSB];
  assign st_low[5]  = cfg_q[9][`LOW_MSB:`LOW_LSB];
  assign st_high[5] = cfg_q[9][`HIGH_MSB:`HIGH_LSB];

  // phase from begin_high_flag and coarse_delay_field
  assign phase0 = {cfg_q[1][`BEGIN_HIGH_BIT], cfg_q[1][3:0]};
  assign phase1 = {cfg_q[3][`BEGIN_HIGH_BIT], cfg_q[3][3:0]};

  function automatic logic [4:0] phase_delay(input logic [4:0] ph, input cnt_field_t low);
    if (ph < `PHASE_WRAP)
      phase_delay = ph;
    else
      phase_delay = 5'(ph - `PHASE_WRAP + {1'b0, low} + 5'h01);
  endfunction : phase_delay

  // dividers 0 and 1 hold their own delay, skew in input cycles; stages 2 to 5 none
  assign st_dly[0] = phase_delay(phase0, st_low[0]);
  assign st_dly[1] = phase_delay(phase1, st_low[1]);
  assign st_dly[2] = 5'h00;
  assign st_dly[3] = 5'h00;
  assign st_dly[4] = 5'h00;
  assign st_dly[5] = 5'h00;

  // first stages count every input cycle, second stages count first-stage periods
  assign st_adv[0] = 1'b1;
  assign st_adv[1] = 1'b1;
  assign st_adv[2] = 1'b1;
  assign st_adv[4] = 1'b1;
  assign st_adv[3] = cfg_q[6][`BYP_FIRST_BIT]  | st_rise[2];
  assign st_adv[5] = cfg_q[10][`BYP_FIRST_BIT] | st_rise[4];

  // ---------------------------------------------------------------
  // divider stages
  // ---------------------------------------------------------------
  logic [3:0] cnt_q [`NUM_STAGES];
  logic [4:0] dly_q [`NUM_STAGES];
  logic [`NUM_STAGES-1:0] hn_q;

  genvar g;
  generate
    for (g = 0; g < `NUM_STAGES; g++)
    begin : gen_stage
      assign st_odd[g]   = st_low[g][0] ^ st_high[g][0];
      assign dly_busy[g] = dly_q[g] != 5'h00;
      assign st_rise[g]  = st_adv[g] & ~dly_busy[g] & (cnt_q[g] == 4'h0) & ~hi_q[g];
      assign st_fall[g]  = st_adv[g] & ~dly_busy[g] & (cnt_q[g] == 4'h0) & hi_q[g];

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          hi_q[g]  <= 1'b1;
          cnt_q[g] <= 4'h0;
          dly_q[g] <= 5'h00;
        end
        else if (sync_q)
        begin
          // phase applied only here
          if (st_dly[g] == 5'h00)
          begin
            hi_q[g]  <= 1'b1;
            cnt_q[g] <= st_high[g];
            dly_q[g] <= 5'h00;
          end
          else
          begin
            hi_q[g]  <= 1'b0;
            cnt_q[g] <= 4'h0;
            dly_q[g] <= st_dly[g];
          end
        end
        else if (st_adv[g])
        begin
          if (dly_busy[g])
          begin
            dly_q[g] <= dly_q[g] - 5'h01;
            if (dly_q[g] == 5'h01)
            begin
              hi_q[g]  <= 1'b1;
              cnt_q[g] <= st_high[g];
            end
          end
          else if (cnt_q[g] == 4'h0)
          begin
            // fields sampled at each phase start only
            hi_q[g]  <= ~hi_q[g];
            cnt_q[g] <= hi_q[g] ? st_low[g] : st_high[g];
          end
          else
          begin
            cnt_q[g] <= cnt_q[g] - 4'h1;
          end
        end
      end

      // half-cycle copy for odd-ratio correction
      always_ff @(negedge clk or posedge rst)
      begin
        if (rst)
          hn_q[g] <= 1'b0;
        else
          hn_q[g] <= hi_q[g];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // cascade tails for second-stage correction
  // ---------------------------------------------------------------
  logic tail2_q;
  logic tail3_q;
  logic tail2_n_q;
  logic tail3_n_q;

  // tail covers the first-stage high after a second-stage fall
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tail2_q <= 1'b0;
    else if (sync_q)
      tail2_q <= 1'b0;
    else if (st_fall[3])
      tail2_q <= 1'b1;
    else if (st_fall[2])
      tail2_q <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tail3_q <= 1'b0;
    else if (sync_q)
      tail3_q <= 1'b0;
    else if (st_fall[5])
      tail3_q <= 1'b1;
    else if (st_fall[4])
      tail3_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // half-cycle tail copies for an odd first stage
  // ---------------------------------------------------------------
  always_ff @(negedge clk or posedge rst)
  begin
    if (rst)
      tail2_n_q <= 1'b0;
    else
      tail2_n_q <= tail2_q;
  end

  always_ff @(negedge clk or posedge rst)
  begin
    if (rst)
      tail3_n_q <= 1'b0;
    else
      tail3_n_q <= tail3_q;
  end

  // ---------------------------------------------------------------
  // channel outputs
  // ---------------------------------------------------------------
  logic dfix2;
  logic dfix3;
  logic s1_out2;
  logic s1_out3;
  casc_mode_t mode2;
  casc_mode_t mode3;
  logic ext2;
  logic ext3;

  // correction on by default, off when duty_fix_disable set
  assign dfix2 = ~cfg_q[7][`DUTY_FIX_OFF_BIT];
  assign dfix3 = ~cfg_q[11][`DUTY_FIX_OFF_BIT];

  // odd first stage stretched by half an input cycle
  assign s1_out2 = hi_q[2] | (dfix2 & st_odd[2] & hn_q[2]);
  assign s1_out3 = hi_q[4] | (dfix3 & st_odd[4] & hn_q[4]);

  // odd second stage stretched by half a first-stage period
  assign ext2 = dfix2 & st_odd[3] & (tail2_q | (st_odd[2] & tail2_n_q));
  assign ext3 = dfix3 & st_odd[5] & (tail3_q | (st_odd[4] & tail3_n_q));

  assign mode2 = casc_mode_t'({cfg_q[6][`BYP_SECOND_BIT], cfg_q[6][`BYP_FIRST_BIT]});
  assign mode3 = casc_mode_t'({cfg_q[10][`BYP_SECOND_BIT], cfg_q[10][`BYP_FIRST_BIT]});

  // dividers 0 and 1: high plus low, or pass-through
  assign chan_clk_out[0] = cfg_q[1][`DIV01_BYPASS_BIT] ? clk : hi_q[0];
  assign chan_clk_out[1] = cfg_q[3][`DIV01_BYPASS_BIT] ? clk : hi_q[1];

  always_comb
  begin
    case (mode2)
      CASC_BOTH_BYP:   chan_clk_out[2] = clk;
      CASC_SECOND_BYP: chan_clk_out[2] = s1_out2;
      CASC_FIRST_BYP:  chan_clk_out[2] = hi_q[3];
      CASC_BOTH_RUN:   chan_clk_out[2] = hi_q[3] | ext2;
      default:         chan_clk_out[2] = 1'b0;
    endcase
  end

  always_comb
  begin
    case (mode3)
      CASC_BOTH_BYP:   chan_clk_out[3] = clk;
      CASC_SECOND_BYP: chan_clk_out[3] = s1_out3;
      CASC_FIRST_BYP:  chan_clk_out[3] = hi_q[5];
      CASC_BOTH_RUN:   chan_clk_out[3] = hi_q[5] | ext3;
      default:         chan_clk_out[3] = 1'b0;
    endcase
  end

endmodule : channel_clock_dividers
`default_nettype wire

// ### src/clk_div_regs.svh
/*
  register indices, field positions, reset values and timing figures of the channel clock dividers.
  assumes APB byte address = 4 x index, data in the low byte of the word, status in bits 11:0.
*/
// Overview of operation
// - phase is start-high bit and offset field
// - phase up to 15 delays edge that many
// - phase 16 up delays phase-16 plus low count
// - dividers 0, 1 phase sets skew in input cycles
// - dividers 2, 3 are two cascaded stages
// - count fields hold cycles minus one
// - divider 2 stage, bypass, correction fields
// - divider 3 stage, bypass, correction fields
// - second bypassed: stage one; else product
// - both bypassed passes input clock through
// - duty correction on unless disable bit set
// - correction off, cascaded: stage two duty
// - correction off, stage one only: its duty
// - correction on gives 50 percent output
// - phase takes effect at sync event only
// - counts use the routed divider input clock
// - dividers 0, 1 divide 2..32, bypass one
`ifndef CLK_DIV_REGS_SVH
`define CLK_DIV_REGS_SVH

`define IDX_CH0_COUNTS   10'h190
`define IDX_CH0_PHASE    10'h191
`define IDX_CH1_COUNTS   10'h196
`define IDX_CH1_PHASE    10'h197
`define IDX_CH2_S1       10'h199
`define IDX_CH2_S2       10'h19B
`define IDX_CH2_BYPASS   10'h19C
`define IDX_CH2_DUTY     10'h19D
`define IDX_CH3_S1       10'h19E
`define IDX_CH3_S2       10'h1A0
`define IDX_CH3_BYPASS   10'h1A1
`define IDX_CH3_DUTY     10'h1A2
`define IDX_SYNC_CTRL    10'h1A4
`define IDX_STATUS       10'h1A8

`define NUM_CFG          4'hC
`define NUM_STAGES       6
`define CFG_RESET        8'h00

`define LOW_MSB          7
`define LOW_LSB          4
`define HIGH_MSB         3
`define HIGH_LSB         0
`define BEGIN_HIGH_BIT   4
`define DIV01_BYPASS_BIT 7
`define BYP_FIRST_BIT    4
`define BYP_SECOND_BIT   5
`define DUTY_FIX_OFF_BIT 0
`define SYNC_BIT         0
`define PHASE_WRAP       5'h10

`endif

// ### src/clk_div_pkg.sv
/*
  types shared by the channel clock divider design.
  assumes nothing beyond the register header.
*/
package clk_div_pkg;

  typedef logic [7:0] cfg_byte_t;
  typedef logic [3:0] cnt_field_t;

  // bypass pair of a cascaded divider, {second, first}
  typedef enum logic [1:0] {
    CASC_BOTH_RUN   = 2'b00,
    CASC_FIRST_BYP  = 2'b01,
    CASC_SECOND_BYP = 2'b10,
    CASC_BOTH_BYP   = 2'b11
  } casc_mode_t;

endpackage : clk_div_pkg

// ### bench/channel_clock_dividers_properties.sv
/*
  apb and channel 0 properties of channel_clock_dividers.
  sees only the top ports; bound from the tb file.
*/
`timescale 1ns/1ps
`default_nettype none
`include "clk_div_regs.svh"
module clk_div_props
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  chan_clk_out
);
  // ------------------------------
  // channel 0 run lengths
  // ------------------------------
  logic [5:0] hi_q;
  logic [5:0] lo_q;
  logic [1:0] hold_q;
  logic       sync_wr;
  logic       clr;
  assign sync_wr = psel && penable && pwrite && paddr[11:2] == `IDX_SYNC_CTRL;
  assign clr     = sync_wr || hold_q != 2'h0;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      hold_q <= 2'h0;
    else if (sync_wr)
      hold_q <= 2'h3;
    else if (hold_q != 2'h0)
      hold_q <= hold_q - 2'h1;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      hi_q <= 6'h00;
      lo_q <= 6'h00;
    end
    else
    begin
      hi_q <= (clr || !chan_clk_out[0]) ? 6'h00 : hi_q + 6'h01;
      lo_q <= (clr || chan_clk_out[0]) ? 6'h00 : lo_q + 6'h01;
    end
  // ------------------------------
  // properties
  // ------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no pready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
  a_ready_in_access: assert property (pready |-> psel && penable) else $error("pready outside access");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_unmapped_err: assert property (psel && !penable && paddr[11:2] < `IDX_CH0_COUNTS |=> pslverr)
    else $error("unmapped access not refused");
  a_mapped_no_err: assert property (psel && !penable && paddr[11:2] == `IDX_CH2_DUTY |=> !pslverr)
    else $error("mapped access refused");
  a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  a_ch0_high_bound: assert property (hi_q <= 6'h10) else $error("channel 0 high too long");
  a_ch0_low_bound: assert property (lo_q <= 6'h10) else $error("channel 0 low too long");
endmodule : clk_div_props
`default_nettype wire

// ### bench/clk_load_model.sv
/*
  load model of the four channel clocks: times the last high, low and rising edge of each.
  assumes a 1 ps time precision.
*/
`timescale 1ns/1ps
`default_nettype none
module clk_load_model
(
  input  wire logic [3:0]       load_clk,
  output var  logic [3:0][63:0] hi_ps,
  output var  logic [3:0][63:0] lo_ps,
  output var  logic [3:0][63:0] rise_ps
);
  for (genvar g = 0; g < 4; g++)
  begin : g_ch
    logic [63:0] fall_ps;
    always @(posedge load_clk[g])
    begin
      rise_ps[g] = longint'($realtime * 1000.0);
      lo_ps[g]   = rise_ps[g] - fall_ps;
    end
    always @(negedge load_clk[g])
    begin
      fall_ps  = longint'($realtime * 1000.0);
      hi_ps[g] = fall_ps - rise_ps[g];
    end
  end
endmodule : clk_load_model
`default_nettype wire

// ### bench/tb.sv
/*
  self-checking bench of channel_clock_dividers: registers, ratios, duty and phase skew.
  assumes the load model and the property checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "clk_div_regs.svh"
module tb;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [11:0]      paddr = 12'h000;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [3:0]       chan_clk_out;
  logic [3:0][63:0] hi_ps;
  logic [3:0][63:0] lo_ps;
  logic [3:0][63:0] rise_ps;
  logic [31:0]      rd;
  logic             err;
  logic [7:0]       v;
  logic [4:0]       p;
  logic [24:0]      c;
  longint           hi;
  longint           per;
  int               ch;
  int               error_cnt = 0;
  int               checks = 0;
  int               seed = 32'h50B0;
  logic [9:0]       regs [12] = '{`IDX_CH0_COUNTS, `IDX_CH0_PHASE, `IDX_CH1_COUNTS, `IDX_CH1_PHASE, `IDX_CH2_S1,
    `IDX_CH2_S2, `IDX_CH2_BYPASS, `IDX_CH2_DUTY, `IDX_CH3_S1, `IDX_CH3_S2, `IDX_CH3_BYPASS, `IDX_CH3_DUTY};
  logic [4:0]       ph [6] = '{5'h00, 5'h01, 5'h0F, 5'h10, 5'h11, 5'h1F};
  // legal programming: first stage never bypassed alone, odd second ratios included
  logic [24:0]      cas [6] = '{{8'h11, 8'h21, 8'h00, 1'b1}, {8'h21, 8'h00, 8'h20, 1'b1},
    {8'h10, 8'h00, 8'h20, 1'b0}, {8'h10, 8'h10, 8'h00, 1'b0}, {8'h00, 8'h00, 8'h30, 1'b0}, {8'hFF, 8'hFF, 8'h00, 1'b0}};

  always #12.5 clk = ~clk;

  channel_clock_dividers channel_clock_dividers_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_clk_out(chan_clk_out));
  clk_load_model clk_load_model_i (.load_clk(chan_clk_out), .hi_ps(hi_ps), .lo_ps(lo_ps), .rise_ps(rise_ps));

  // ------------------------------
  // helpers
  // ------------------------------
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    int n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    chk("pready", pready, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0, d});
  endtask : wr

  task automatic meas(input int k, input longint h, input longint t);
    wr(`IDX_SYNC_CTRL, 8'h01);
    repeat (3 * (t / 25000) + 40) @(posedge clk);
    chk("high_time", hi_ps[k], h);
    chk("low_time", lo_ps[k], t - h);
  endtask : meas

  function automatic longint casc(input logic [24:0] x, output longint h);
    longint d1 = x[24:21] + x[20:17] + 2;
    longint d2 = x[16:13] + x[12:9] + 2;
    longint t = (x[6:5] == 2'b11) ? 25000 : (x[6] ? d1 : d1 * d2) * 25000;
    h = x[0] ? (x[6] ? x[20:17] + 1 : (x[12:9] + 1) * d1) * 25000 : t / 2;
    return t;
  endfunction : casc

  task end_of_test;
    $display("error_cnt=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (regs[i])
    begin
      apb(1'b0, regs[i], 32'h0);
      chk("reset_value", {err, rd}, 33'h0);
      v = 8'($random(seed)) & (i == 1 ? 8'h7F : 8'hFF);
      wr(regs[i], v);
      apb(1'b0, regs[i], 32'h0);
      chk("read_back", {err, rd}, {25'h0, v});
    end
    apb(1'b0, 10'h000, 32'h0);
    chk("unmapped_read", {err, rd}, {1'b1, 32'h0});
    apb(1'b1, 10'h000, 32'h0000_00FF);
    chk("unmapped_write", err, 1'b1);
    apb(1'b0, `IDX_STATUS, 32'h0);
    chk("status_idle", {err, rd[31:6]}, 27'h0);
    wr(`IDX_CH0_PHASE, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      v = i < 2 ? {8{i[0]}} : 8'($random(seed));
      wr(`IDX_CH0_COUNTS, v);
      meas(0, (v[3:0] + 1) * 25000, (v[7:4] + v[3:0] + 2) * 25000);
    end
    wr(`IDX_CH1_PHASE, 8'h80);
    meas(1, 12500, 25000);
    wr(`IDX_CH0_COUNTS, 8'h7F);
    wr(`IDX_CH1_COUNTS, 8'h7F);
    for (int i = 0; i < 7; i++)
    begin
      p = i < 6 ? ph[i] : 5'($random(seed));
      wr(`IDX_CH1_PHASE, {3'h0, p});
      meas(1, 400000, 600000);
      chk("skew", (rise_ps[1] + 600000 - rise_ps[0]) % 600000, (p < 16 ? p : p - 8) * 25000);
    end
    for (int i = 0; i < 8; i++)
    begin
      ch = 2 + i % 2;
      c = i < 6 ? cas[i] : {16'($random(seed)), 9'h001};
      wr(ch == 2 ? `IDX_CH2_S1 : `IDX_CH3_S1, c[24:17]);
      wr(ch == 2 ? `IDX_CH2_S2 : `IDX_CH3_S2, c[16:9]);
      wr(ch == 2 ? `IDX_CH2_BYPASS : `IDX_CH3_BYPASS, c[8:1]);
      wr(ch == 2 ? `IDX_CH2_DUTY : `IDX_CH3_DUTY, {7'h00, c[0]});
      per = casc(c, hi);
      meas(ch, hi, per);
    end
    end_of_test;
  end

  initial
  begin
    #1000000;
    error_cnt++;
    end_of_test;
  end
endmodule : tb

bind channel_clock_dividers clk_div_props clk_div_props_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .chan_clk_out(chan_clk_out));
`default_nettype wire
